// file: verilog/sdc_pkg.sv
/*
  Holds the shared constants of the daisy-chain serial slave link.
  Assumes both ends run on one 200 MHz system clock.
*/
// Operation
// R1: select falling edge starts a frame
// R2: sample input on falling, shift output rising
// R3: master raises select; device acts then
// R4: accept 16 clocks plus multiples of 8
// R5: bad count sets error, discards frame
// R6: select high: ignore lines, output released
// R7: select falling loads response into shifter
// R8: output starts as error OR serial input
// R9: sleep keeps output released, no transfer
// R10: good frame copies shifter into register
// R11: master keeps clock low around select edges
// R12: most significant bit first both ways
// R13: frame is control bits then data
// R14: one shifter passes displaced bits onward
// R15: sixteen clocks per device, extras pass on
// R16: master shifts whole bytes per device
// R17: counter cleared at start, wraps after 16
package sdc_pkg;
  // ==========================================================
  // frame geometry
  localparam int unsigned SDC_FRAME_BITS = 16;
  localparam int unsigned SDC_EXTRA_MOD  = 8;
  localparam int unsigned SDC_CNT_W      = 5;
  localparam logic [4:0]  SDC_CNT_RST    = 5'h00;
  // ==========================================================
  // timing
  localparam int unsigned SDC_SYS_NS     = 5;
  localparam int unsigned SDC_LEAD_NS    = 200;
  localparam int unsigned SDC_HALF_NS    = 100;
  localparam int unsigned SDC_LEAD_CYC   =
    (SDC_LEAD_NS + SDC_SYS_NS - 1) / SDC_SYS_NS;
  localparam int unsigned SDC_HALF_CYC   =
    (SDC_HALF_NS + SDC_SYS_NS - 1) / SDC_SYS_NS;
  localparam int unsigned SDC_TMR_W      = 8;
endpackage

// file: verilog/sdc_link_if.sv
/*
  Carries the four serial lines between master and slave ends.
  Assumes the bench resolves the released output line.
*/
interface sdc_link_if;
  logic frame_select_n;
  logic sclk;
  logic master_serial_out;
  logic so_o;
  logic so_oe;
  modport slave (
    input  frame_select_n,
    input  sclk,
    input  master_serial_out,
    output so_o,
    output so_oe
  );
  modport master (
    output frame_select_n,
    output sclk,
    output master_serial_out,
    input  so_o,
    input  so_oe
  );
endinterface

// file: verilog/sdc_master.sv
/*
  Serial master end: sends one frame of bit_count clocks.
  Assumes the slave output reads low when released.
*/
module sdc_master
  import sdc_pkg::*;
#(
  parameter int unsigned FRAME_W = 16
) (
  input  wire logic               sys_clk,
  input  wire logic               resetn,
  input  wire logic               clk_en,
  sdc_link_if.master              link,
  input  wire logic               start,
  input  wire logic [FRAME_W-1:0] tx_data,
  input  wire logic [5:0]         bit_count,
  output logic                    busy_r,
  output logic                    done_r,
  output logic [FRAME_W-1:0]      rx_data_r
);
  typedef enum logic [3:0] {
    SDC_M_IDLE = 4'b0001,
    SDC_M_LEAD = 4'b0010,
    SDC_M_HIGH = 4'b0100,
    SDC_M_LOW  = 4'b1000
  } sdc_mst_e;
  sdc_mst_e             st_r;
  logic [SDC_TMR_W-1:0] tmr_r;
  logic [5:0]           left_r;
  logic [FRAME_W-1:0]   tx_r;
  logic                 csn_r;
  logic                 sck_r;
  logic                 mi_s1_r;
  logic                 mi_s2_r;
  logic                 oe_s1_r;
  logic                 oe_s2_r;

  assign link.frame_select_n    = csn_r;
  assign link.sclk              = sck_r;
  assign link.master_serial_out = tx_r[FRAME_W-1]; // see R12

  // ==========================================================
  // input synchroniser
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      mi_s1_r <= 1'b0;
      mi_s2_r <= 1'b0;
      oe_s1_r <= 1'b0;
      oe_s2_r <= 1'b0;
    end else if (clk_en) begin
      mi_s1_r <= link.so_o;
      mi_s2_r <= mi_s1_r;
      oe_s1_r <= link.so_oe;
      oe_s2_r <= oe_s1_r;
    end
  end

  // ==========================================================
  // frame sequencer, clock divided from sys_clk
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      st_r      <= SDC_M_IDLE;
      tmr_r     <= '0;
      left_r    <= '0;
      tx_r      <= '0;
      csn_r     <= 1'b1;
      sck_r     <= 1'b0;
      busy_r    <= 1'b0;
      done_r    <= 1'b0;
      rx_data_r <= '0;
    end else if (clk_en) begin
      done_r <= 1'b0;
      unique case (st_r)
        SDC_M_IDLE: begin
          if (start && bit_count != 6'h00) begin
            tx_r   <= tx_data; // see R13
            left_r <= bit_count; // see R16
            csn_r  <= 1'b0; // see R1
            busy_r <= 1'b1;
            tmr_r  <= SDC_TMR_W'(SDC_LEAD_CYC);
            st_r   <= SDC_M_LEAD;
          end
        end
        SDC_M_LEAD: begin
          if (tmr_r != '0) begin
            tmr_r <= tmr_r - 1'b1;
          end else begin
            sck_r <= 1'b1;
            tmr_r <= SDC_TMR_W'(SDC_HALF_CYC);
            st_r  <= SDC_M_HIGH;
          end
        end
        SDC_M_HIGH: begin
          if (tmr_r != '0) begin
            tmr_r <= tmr_r - 1'b1;
          end else begin
            sck_r     <= 1'b0;
            rx_data_r <= {rx_data_r[FRAME_W-2:0], mi_s2_r & oe_s2_r};
            left_r    <= left_r - 1'b1;
            tmr_r     <= SDC_TMR_W'(SDC_HALF_CYC);
            st_r      <= SDC_M_LOW;
          end
        end
        SDC_M_LOW: begin
          if (tmr_r != '0) begin
            tmr_r <= tmr_r - 1'b1;
          end else if (left_r != 6'h00) begin
            sck_r <= 1'b1;
            // next bit on the rise, so it stands across the fall
            tx_r  <= {tx_r[FRAME_W-2:0], 1'b0}; // see R12
            tmr_r <= SDC_TMR_W'(SDC_HALF_CYC);
            st_r  <= SDC_M_HIGH;
          end else begin
            csn_r  <= 1'b1; // see R3 R11
            busy_r <= 1'b0;
            done_r <= 1'b1;
            st_r   <= SDC_M_IDLE;
          end
        end
      endcase
    end
  end
endmodule

// file: verilog/sdc_slave.sv
/*
  Serial slave end: shifter, frame counter, error flag.
  Assumes link lines are asynchronous and sampled here,
  that the far end resolves the released output line,
  and that clk_en low holds every flop of the block.
*/
module sdc_slave
  import sdc_pkg::*;
#(
  parameter int unsigned FRAME_W = 16
) (
  input  wire logic               sys_clk,
  input  wire logic               resetn,
  input  wire logic               clk_en,
  sdc_link_if.slave               link,
  input  wire logic               sleep,
  input  wire logic [FRAME_W-1:0] resp_data,
  output logic [FRAME_W-1:0]      reg_data_r,
  output logic                    reg_we_r,
  output logic                    transfer_error_flag_r,
  input  wire logic               err_clr
);
  typedef enum logic [2:0] {
    SDC_S_IDLE  = 3'b001,
    SDC_S_FRAME = 3'b010,
    SDC_S_SLEEP = 3'b100
  } sdc_slv_e;
  sdc_slv_e             st_r;
  logic [2:0]           csn_s_r;
  logic [2:0]           sck_s_r;
  logic [1:0]           si_s_r;
  logic [FRAME_W-1:0]   sh_r;
  logic [SDC_CNT_W-1:0] cnt_r;
  logic                 so_r;
  logic                 oe_r;
  logic                 csn_fall;
  logic                 csn_rise;
  logic                 sck_fall;
  logic                 sck_rise;
  logic                 cnt_ok;
  logic                 frame_end;

  // ==========================================================
  // helpers
  // frame length check: 16 then whole bytes
  // counter wraps back to 16, so every valid length ends there
  function automatic logic sdc_len_ok(input logic [SDC_CNT_W-1:0] c);
    return c == SDC_CNT_W'(SDC_FRAME_BITS); // see R4
  endfunction

  // high to low between the last two stages
  function automatic logic sdc_fell(input logic [2:0] s);
    return s[2] & ~s[1];
  endfunction

  // low to high between the last two stages
  function automatic logic sdc_rose(input logic [2:0] s);
    return ~s[2] & s[1];
  endfunction

  assign link.so_o  = so_r;
  assign link.so_oe = oe_r;
  assign csn_fall  = sdc_fell(csn_s_r);
  assign csn_rise  = sdc_rose(csn_s_r);
  assign sck_fall  = sdc_fell(sck_s_r);
  assign sck_rise  = sdc_rose(sck_s_r);
  assign cnt_ok    = sdc_len_ok(cnt_r);
  assign frame_end = (st_r == SDC_S_FRAME) && csn_rise;

  // ==========================================================
  // synchronisers and edge finders
  // third stage only feeds the edge finders
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      csn_s_r <= 3'h7;
    end else if (clk_en) begin
      csn_s_r <= {csn_s_r[1:0], link.frame_select_n};
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      sck_s_r <= 3'h0;
    end else if (clk_en) begin
      sck_s_r <= {sck_s_r[1:0], link.sclk};
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      si_s_r <= 2'h0;
    end else if (clk_en) begin
      si_s_r <= {si_s_r[0], link.master_serial_out};
    end
  end

  // ==========================================================
  // frame state
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      st_r <= SDC_S_IDLE;
    end else if (clk_en) begin
      unique case (st_r)
        SDC_S_IDLE: begin
          if (csn_fall) begin
            st_r <= sleep ? SDC_S_SLEEP : SDC_S_FRAME; // see R1 R9
          end
        end
        SDC_S_FRAME, SDC_S_SLEEP: begin
          if (csn_rise) begin
            st_r <= SDC_S_IDLE; // see R3
          end
        end
        default: st_r <= SDC_S_IDLE;
      endcase
    end
  end

  // ==========================================================
  // clock counter, wraps to 16 after 23
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      cnt_r <= SDC_CNT_RST;
    end else if (clk_en) begin
      if (csn_fall) begin
        cnt_r <= SDC_CNT_RST; // see R17
      end else if (st_r == SDC_S_FRAME && sck_fall) begin
        if (cnt_r == SDC_CNT_W'(SDC_FRAME_BITS + SDC_EXTRA_MOD - 1)) begin
          cnt_r <= SDC_CNT_W'(SDC_FRAME_BITS); // see R17 R15
        end else begin
          cnt_r <= cnt_r + 1'b1;
        end
      end
    end
  end

  // ==========================================================
  // shifter
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      sh_r <= '0;
    end else if (clk_en) begin
      if (csn_fall) begin
        sh_r <= resp_data; // see R7
      end else if (st_r == SDC_S_FRAME && !csn_rise && sck_fall) begin
        sh_r <= {sh_r[FRAME_W-2:0], si_s_r[1]}; // see R2 R14
      end
    end
  end

  // ==========================================================
  // serial output level
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      so_r <= 1'b0;
    end else if (clk_en) begin
      if (csn_fall) begin
        so_r <= transfer_error_flag_r | si_s_r[1]; // see R8
      end else if (st_r == SDC_S_FRAME && !csn_rise && sck_rise) begin
        so_r <= sh_r[FRAME_W-1]; // see R2 R12 R14
      end
    end
  end

  // ==========================================================
  // serial output enable
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      oe_r <= 1'b0;
    end else if (clk_en) begin
      if (csn_fall) begin
        oe_r <= ~sleep; // see R9
      end else if (csn_rise || st_r != SDC_S_FRAME) begin
        oe_r <= 1'b0; // see R6
      end
    end
  end

  // ==========================================================
  // frame end: commit
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      reg_data_r <= '0;
      reg_we_r   <= 1'b0;
    end else if (clk_en) begin
      reg_we_r <= 1'b0;
      if (frame_end && cnt_ok) begin
        reg_data_r <= sh_r; // see R10
        reg_we_r   <= 1'b1;
      end
    end
  end

  // ==========================================================
  // transfer error flag
  // a bad frame ending on a clear keeps the flag set
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      transfer_error_flag_r <= 1'b0;
    end else if (clk_en) begin
      if (frame_end && !cnt_ok) begin
        transfer_error_flag_r <= 1'b1; // see R5
      end else if (err_clr && !(csn_fall || csn_rise)) begin
        transfer_error_flag_r <= 1'b0;
      end
    end
  end
endmodule

// file: sim/sdc_link_asserts.sv
/*
  checker for the four serial lines between the two ends.
  assumes one sys_clk domain and the active-low resetn.
*/
module sdc_link_asserts (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic frame_select_n,
  input wire logic sclk,
  input wire logic master_serial_out,
  input wire logic so_o,
  input wire logic so_oe
);
  timeunit 1ns;
  timeprecision 1ps;
  // ========================================================
  // line timing
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  a_oe_idle_off:
    assert property (frame_select_n [*5] |-> !so_oe)
    else $error("so driven while deselected");
  a_oe_release:
    assert property ($rose(frame_select_n) |-> ##[2:5] !so_oe)
    else $error("so not released after frame");
  a_so_rise_edge:
    assert property (so_oe && $past(so_oe) && $changed(so_o)
      |-> $past(sclk, 2) && $past(sclk, 3))
    else $error("so moved away from clock rise");
  a_clk_low_sel:
    assert property ($changed(frame_select_n) |-> !sclk)
    else $error("clock high at select edge");
  a_lead_time:
    assert property ($fell(frame_select_n)
      |-> !sclk [*8] ##[32:34] $rose(sclk))
    else $error("lead time wrong");
  a_clk_high:
    assert property ($rose(sclk) |-> sclk [*8] ##[12:14] $fell(sclk))
    else $error("clock high time wrong");
  a_lag_time:
    assert property ($fell(sclk)
      |-> (!frame_select_n && !sclk) [*8])
    else $error("lag time too short");
  a_si_steady:
    assert property (sclk && $past(sclk) |-> $stable(master_serial_out))
    else $error("si moved while clock high");
endmodule

// file: sim/tb_top.sv
/*
  bench for both ends of the serial link, joined by one interface.
  assumes the master makes the link clock from sys_clk.
*/
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        sys_clk    = 1'b0;
  logic        resetn     = 1'b0;
  logic        start      = 1'b0;
  logic        sleep      = 1'b0;
  logic        err_clr    = 1'b0;
  logic [15:0] tx         = 16'h0000;
  logic [15:0] resp       = 16'h0000;
  logic [5:0]  cnt        = 6'h10;
  logic        busy;
  logic        done;
  logic        we;
  logic        flag;
  logic [15:0] rx;
  logic [15:0] reg_q;
  logic        ef         = 1'b0;
  int          fail_count = 0;
  int          cmp_count  = 0;
  int          we_n       = 0;
  int          oe_n       = 0;
  int          ns [8]     = '{16, 24, 17, 16, 32, 23, 48, 8};
  sdc_link_if  link ();
  // ========================================================
  // ends and checker
  sdc_master u_sdc_master (.sys_clk, .resetn, .clk_en(1'b1), .link,
    .start, .tx_data(tx), .bit_count(cnt), .busy_r(busy),
    .done_r(done), .rx_data_r(rx));
  sdc_slave u_sdc_slave (.sys_clk, .resetn, .clk_en(1'b1), .link,
    .sleep, .resp_data(resp), .reg_data_r(reg_q), .reg_we_r(we),
    .transfer_error_flag_r(flag), .err_clr);
  sdc_link_asserts u_sdc_link_asserts (.sys_clk, .resetn,
    .frame_select_n(link.frame_select_n), .sclk(link.sclk),
    .master_serial_out(link.master_serial_out), .so_o(link.so_o),
    .so_oe(link.so_oe));
  initial begin
    forever #2.5 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    if (we === 1'b1) we_n <= we_n + 1;
    if (link.so_oe === 1'b1) oe_n <= oe_n + 1;
  end
  // ========================================================
  // tasks
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wrap_up();
    $display("compares %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic frame(input int n, input logic [15:0] t,
                       input logic [15:0] r, input logic slp);
    int          k;
    int          w0;
    int          o0;
    logic        ok;
    logic        e0;
    logic [15:0] q0;
    logic [79:0] c;
    c = {r, t, 48'h0};
    ok = n >= 16 && (n - 16) % 8 == 0 && !slp;
    q0 = reg_q;
    w0 = we_n;
    o0 = oe_n;
    e0 = ef;
    tx <= t;
    resp <= r;
    cnt <= 6'(n);
    sleep <= slp;
    start <= 1'b1;
    @(posedge sys_clk);
    start <= 1'b0;
    k = 0;
    while (done !== 1'b1) begin
      @(posedge sys_clk);
      k++;
      if (k == 1)
        check(16'(busy), 16'h0001);
      if (link.so_oe === 1'b1 && e0 === 1'b1 && k < 10)
        check(16'(link.so_o), 16'h0001);
      if (k > 3000) begin
        fail_count++;
        wrap_up();
      end
    end
    repeat (8) @(posedge sys_clk);
    ef = ef | (!ok && !slp);
    check(16'(busy), 16'h0000);
    check(16'(we_n - w0), 16'(ok));
    check(reg_q, ok ? c[79-n -: 16] : q0);
    check(16'(flag), 16'(ef));
    check(16'(oe_n == o0), 16'(slp));
    if (n >= 16)
      check(rx, slp ? 16'h0000 : c[95-n -: 16]);
  endtask
  task automatic clr();
    err_clr <= 1'b1;
    @(posedge sys_clk);
    err_clr <= 1'b0;
    ef = 1'b0;
    repeat (3) @(posedge sys_clk);
    check(16'(flag), 16'h0000);
  endtask
  // ========================================================
  // sequence
  initial begin
    repeat (16) @(posedge sys_clk);
    resetn <= 1'b1;
    @(posedge sys_clk);
    foreach (ns[i]) begin
      frame(ns[i], 16'hA5C3 + 16'(i * 293), 16'h3C5A + 16'(i), 1'b0);
    end
    clr();
    frame(17, 16'h0F0F, 16'hFFFF, 1'b1);
    frame(16, 16'hC001, 16'h8421, 1'b0);
    wrap_up();
  end
endmodule
